// file: rtl/gst_timer.sv
// Gated sixteen-bit timer/counter with AXI4-Lite register access
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Clock source field picks count clock
// - Prescale field divides by 1, 2, 4, 8
// - Oscillator enable picks secondary oscillator or pin
// - External clock synchronised unless sync bit set
// - Sync bit ignored for internal clocks
// - On bit enables counting
// - One readable writable 16-bit count register
// - Special event trigger clears count
// - Gate enable matters only while timer on
// - Gate polarity selects active level
// - Toggle mode flips gate each rising edge
// - Toggle flip-flop held clear when mode off
// - Single-pulse bit puts one-shot logic in control
// - Go/done reads one while armed and waiting
// - Go/done cleared when single-pulse mode cleared
// - Gate value bit shows gate, ignores enable
// - Gate source field picks pin, period, comparators
// - Upper bytes and control bit 1 read zero
module gst_timer (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    // Count and gate sources
    input  wire gst_pkg::gst_clk_in_s  clkIn,
    input  wire gst_pkg::gst_gate_in_s gateIn,
    input  wire logic             specialEventTrigger,
    // Status out
    output logic                  overflowPulse,
    output logic                  overflowFlag,
    // AXI4-Lite write address and data
    input  wire logic [3:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    // AXI4-Lite read
    input  wire logic [3:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready
);
    import gst_pkg::*;

    logic [7:0]  control_q;
    logic [7:0]  gateCtl_q;
    logic [15:0] count_q;
    logic        overflow_q;
    logic        overflowPulse_q;
    logic [3:0]  awAddr_q;
    logic        awHeld_q;
    logic [31:0] wData_q;
    logic [3:0]  wStrb_q;
    logic        wHeld_q;
    logic        bValid_q;
    logic [1:0]  bResp_q;
    logic        arReady_q;
    logic        rValid_q;
    logic [31:0] rData_q;
    logic [1:0]  rResp_q;

    // Bus write handshake: address and data taken in either order; a misaligned write completes but changes nothing
    logic doWrite;
    logic wrControl;
    logic wrGate;
    logic wrCount;
    logic wrStatus;
    assign doWrite   = awHeld_q && wHeld_q && !bValid_q;
    assign wrControl = doWrite && awAddr_q == OFF_CONTROL && wStrb_q[0];
    assign wrGate    = doWrite && awAddr_q == OFF_GATE_CONTROL && wStrb_q[0];
    assign wrCount   = doWrite && awAddr_q == OFF_COUNT_VALUE;
    assign wrStatus  = doWrite && awAddr_q == OFF_STATUS && wStrb_q[0];

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            awHeld_q <= 1'b0;
            awAddr_q <= 4'h0;
        end else if (!awHeld_q && s_axi_awvalid) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wHeld_q <= 1'b0;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
        end else if (!wHeld_q && s_axi_wvalid) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
        end else if (doWrite) begin
            wHeld_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bValid_q <= 1'b0;
            bResp_q  <= RESP_OKAY;
        end else if (doWrite) begin
            bValid_q <= 1'b1;
            bResp_q  <= RESP_OKAY;
        end else if (s_axi_bready) begin
            bValid_q <= 1'b0;
        end
    end

    // Control register; bit 1 has no storage
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            control_q <= CONTROL_RESET;
        end else if (wrControl) begin
            control_q <= wData_q[7:0] & CONTROL_WMASK;
        end
    end

    // Source selection
    gst_clk_src_e  clkSrc;
    gst_gate_src_e gateSrc;
    assign clkSrc  = gst_clk_src_e'(control_q[CTL_SRC_LO +: 2]);
    assign gateSrc = gst_gate_src_e'(gateCtl_q[GCT_SRC_LO +: 2]);

    // The external clock pin and secondary oscillator pass a two-stage synchroniser; the sync bit picks the direct path
    logic extRaw;
    logic extMeta_q;
    logic extSync_q;
    logic extPrev_q;
    logic extLevel;
    logic instrTick_q;
    logic lprcPrev_q;
    logic srcTick;

    assign extRaw = control_q[CTL_OSC_EN] ? clkIn.secondaryOsc : clkIn.extClkPin;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            extMeta_q <= 1'b0;
            extSync_q <= 1'b0;
        end else begin
            extMeta_q <= extRaw;
            extSync_q <= extMeta_q;
        end
    end

    // sync bit set bypasses the synchroniser
    assign extLevel = control_q[CTL_SYNC] ? extRaw : extSync_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            extPrev_q   <= 1'b0;
            lprcPrev_q  <= 1'b0;
            instrTick_q <= 1'b0;
        end else begin
            extPrev_q   <= extLevel;
            lprcPrev_q  <= clkIn.lowPowerRcOsc;
            instrTick_q <= ~instrTick_q;
        end
    end

    // one count tick per source clock; internal sources ignore sync bit
    always_comb begin
        unique case (clkSrc)
            CLK_SYSTEM:      srcTick = 1'b1;
            CLK_INSTRUCTION: srcTick = instrTick_q;
            CLK_EXTERNAL:    srcTick = extLevel && !extPrev_q;
            CLK_LOW_POWER:   srcTick = clkIn.lowPowerRcOsc && !lprcPrev_q;
        endcase
    end

    // Gate path
    logic gateRaw;
    logic gatePrev_q;
    logic gateToggle_q;
    logic gateActive;
    logic gateLevel;
    logic goDone_q;
    logic pulseOpen_q;
    logic gateAllowed;

    always_comb begin
        unique case (gateSrc)
            GATE_PIN:    gateRaw = gateIn.extGatePin;
            GATE_PERIOD: gateRaw = gateIn.periodMatch;
            GATE_COMP1:  gateRaw = gateIn.comp1Out;
            GATE_COMP2:  gateRaw = gateIn.comp2Out;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            gatePrev_q <= 1'b0;
        end else begin
            gatePrev_q <= gateRaw;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            gateToggle_q <= 1'b0;
        end else if (!gateCtl_q[GCT_TOGGLE]) begin
            gateToggle_q <= 1'b0;
        end else if (gateRaw && !gatePrev_q) begin
            gateToggle_q <= ~gateToggle_q;
        end
    end

    logic gateSel;
    assign gateSel = gateCtl_q[GCT_TOGGLE] ? gateToggle_q : gateRaw;
    assign gateActive = gateCtl_q[GCT_POLARITY] ? gateSel : ~gateSel;

    // one-shot window opens on active edge while armed, closes on its end
    logic gateActPrev_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            gateActPrev_q <= 1'b0;
        end else begin
            gateActPrev_q <= gateActive;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pulseOpen_q <= 1'b0;
        end else if (!gateCtl_q[GCT_SPM]) begin
            pulseOpen_q <= 1'b0;
        end else if (goDone_q && gateActive && !gateActPrev_q) begin
            pulseOpen_q <= 1'b1;
        end else if (!gateActive) begin
            pulseOpen_q <= 1'b0;
        end
    end

    // single-pulse logic owns the gate when enabled
    assign gateLevel = gateCtl_q[GCT_SPM] ? (pulseOpen_q && gateActive) : gateActive;

    // Gate control register and go/done
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            gateCtl_q <= GATE_RESET;
        end else if (wrGate) begin
            gateCtl_q <= wData_q[7:0] & GATE_WMASK;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            goDone_q <= 1'b0;
        end else if (wrGate && !wData_q[GCT_SPM]) begin
            goDone_q <= 1'b0;
        end else if (!gateCtl_q[GCT_SPM] && !wrGate) begin
            goDone_q <= 1'b0;
        end else if (goDone_q && pulseOpen_q && !gateActive) begin
            // done once the pulse has passed
            goDone_q <= 1'b0;
        end else if (wrGate) begin
            goDone_q <= wData_q[GCT_GO_DONE];
        end
    end

    // gate only matters when enabled and timer on
    assign gateAllowed = !gateCtl_q[GCT_ENABLE] || gateLevel;

    // Prescaler
    logic [2:0] preCnt_q;
    logic [2:0] preLimit;
    logic       countTick;
    always_comb begin
        unique case (control_q[CTL_PRE_LO +: 2])
            2'b00: preLimit = PRE_DIV1;
            2'b01: preLimit = PRE_DIV2;
            2'b10: preLimit = PRE_DIV4;
            2'b11: preLimit = PRE_DIV8;
        endcase
    end

    logic advance;
    // on bit gates every source tick
    assign advance = control_q[CTL_ON] && srcTick && gateAllowed;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            preCnt_q <= 3'h0;
        end else if (wrControl || wrCount) begin
            preCnt_q <= 3'h0;
        end else if (advance) begin
            // divide by 1, 2, 4 or 8
            preCnt_q <= (preCnt_q >= preLimit) ? 3'h0 : preCnt_q + 3'h1;
        end
    end
    assign countTick = advance && (preCnt_q >= preLimit);

    // Counter
    logic rollOver;
    assign rollOver = countTick && count_q == 16'hffff && !specialEventTrigger && !wrCount;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= COUNT_RESET;
        end else if (specialEventTrigger) begin
            count_q <= COUNT_RESET;
        end else if (wrCount) begin
            // software writes the count, byte lanes honoured
            count_q[7:0]  <= wStrb_q[0] ? wData_q[7:0] : count_q[7:0];
            count_q[15:8] <= wStrb_q[1] ? wData_q[15:8] : count_q[15:8];
        end else if (countTick) begin
            count_q <= count_q + 16'h0001;
        end
    end

    // sticky overflow, set wins over write-one clear
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            overflow_q      <= 1'b0;
            overflowPulse_q <= 1'b0;
        end else begin
            overflowPulse_q <= rollOver;
            if (rollOver) begin
                overflow_q <= 1'b1;
            end else if (wrStatus && wData_q[STS_OVERFLOW]) begin
                overflow_q <= 1'b0;
            end
        end
    end

    // Read channel; one-cycle answer after address is taken
    logic [31:0] rdValue;
    logic        rdHit;
    always_comb begin
        rdValue = 32'h0000_0000;
        rdHit   = 1'b1;
        unique case (s_axi_araddr[3:2])
            OFF_CONTROL[3:2]: rdValue[7:0] = control_q;
            OFF_GATE_CONTROL[3:2]: begin
                rdValue[7:0] = gateCtl_q;
                rdValue[GCT_GO_DONE] = goDone_q;
                // live gate state, independent of enable
                rdValue[GCT_VALUE] = gateLevel;
            end
            OFF_COUNT_VALUE[3:2]: rdValue[15:0] = count_q;
            OFF_STATUS[3:2]: rdValue[STS_OVERFLOW] = overflow_q;
        endcase
        if (s_axi_araddr[1:0] != 2'b00) begin
            rdHit = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            arReady_q <= 1'b1;
            rValid_q  <= 1'b0;
            rData_q   <= 32'h0000_0000;
            rResp_q   <= RESP_OKAY;
        end else if (arReady_q && s_axi_arvalid) begin
            arReady_q <= 1'b0;
            rValid_q  <= 1'b1;
            rData_q   <= rdHit ? rdValue : 32'h0000_0000;
            rResp_q   <= rdHit ? RESP_OKAY : RESP_SLVERR;
        end else if (rValid_q && s_axi_rready) begin
            rValid_q  <= 1'b0;
            arReady_q <= 1'b1;
        end
    end

    assign s_axi_awready = !awHeld_q;
    assign s_axi_wready  = !wHeld_q;
    assign s_axi_bvalid  = bValid_q;
    assign s_axi_bresp   = bResp_q;
    assign s_axi_arready = arReady_q;
    assign s_axi_rvalid  = rValid_q;
    assign s_axi_rdata   = rData_q;
    assign s_axi_rresp   = rResp_q;
    assign overflowPulse = overflowPulse_q;
    assign overflowFlag  = overflow_q;

endmodule : gst_timer

`default_nettype wire

// file: rtl/gst_pkg.sv
// Package for the gated sixteen-bit timer: register map, fields, encodings
package gst_pkg;

    // Register byte offsets on the AXI4-Lite bus
    localparam logic [3:0] OFF_CONTROL      = 4'h0;
    localparam logic [3:0] OFF_GATE_CONTROL = 4'h4;
    localparam logic [3:0] OFF_COUNT_VALUE  = 4'h8;
    localparam logic [3:0] OFF_STATUS       = 4'hc;

    // Reset values
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [7:0]  GATE_RESET    = 8'h00;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;

    // Control register fields
    localparam int CTL_ON        = 0;
    localparam int CTL_SYNC      = 2;
    localparam int CTL_OSC_EN    = 3;
    localparam int CTL_PRE_LO    = 4;
    localparam int CTL_SRC_LO    = 6;
    localparam logic [7:0] CONTROL_WMASK = 8'hfd;

    // Gate control register fields
    localparam int GCT_SRC_LO    = 0;
    localparam int GCT_VALUE     = 2;
    localparam int GCT_GO_DONE   = 3;
    localparam int GCT_SPM       = 4;
    localparam int GCT_TOGGLE    = 5;
    localparam int GCT_POLARITY  = 6;
    localparam int GCT_ENABLE    = 7;
    localparam logic [7:0] GATE_WMASK = 8'hf3;

    // Status register: overflow flag, write one to clear
    localparam int STS_OVERFLOW = 0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        CLK_SYSTEM      = 2'b00,
        CLK_INSTRUCTION = 2'b01,
        CLK_EXTERNAL    = 2'b10,
        CLK_LOW_POWER   = 2'b11
    } gst_clk_src_e;

    typedef enum logic [1:0] {
        GATE_PIN        = 2'b00,
        GATE_PERIOD     = 2'b01,
        GATE_COMP1      = 2'b10,
        GATE_COMP2      = 2'b11
    } gst_gate_src_e;

    // Prescale divide-by minus one, indexed by prescale_sel
    localparam logic [2:0] PRE_DIV1 = 3'h0;
    localparam logic [2:0] PRE_DIV2 = 3'h1;
    localparam logic [2:0] PRE_DIV4 = 3'h3;
    localparam logic [2:0] PRE_DIV8 = 3'h7;

    // Clock and gate source inputs travel together
    typedef struct packed {
        logic lowPowerRcOsc;
        logic secondaryOsc;
        logic extClkPin;
    } gst_clk_in_s;

    typedef struct packed {
        logic comp2Out;
        logic comp1Out;
        logic periodMatch;
        logic extGatePin;
    } gst_gate_in_s;

endpackage : gst_pkg

// file: verification/gst_timer_monitor.sv
// Port checker for the gated timer
`timescale 1ns/10ps
`default_nettype none
module gst_timer_monitor (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        reset_n,
    // Timer side
    input wire logic        specialEventTrigger,
    input wire logic        overflowPulse,
    input wire logic        overflowFlag,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [3:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    import gst_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    chk_arready_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
    chk_misalign_zero: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("misaligned read not refused");
    chk_upper_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_OKAY |->
        s_axi_rdata[31:16] == 16'h0)
        else $error("upper half of read word not zero");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    chk_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == RESP_OKAY)
        else $error("write response not okay");
    chk_pulse_single: assert property (overflowPulse |=> !overflowPulse)
        else $error("overflow pulse longer than one cycle");
    chk_pulse_flag: assert property (overflowPulse |-> ##[0:1] overflowFlag)
        else $error("overflow pulse without flag");
    chk_trigger_quiet: assert property (specialEventTrigger [*3] |=> !overflowPulse)
        else $error("overflow while count held clear");
endmodule : gst_timer_monitor

bind gst_timer gst_timer_monitor i_mon (.sys_clk, .reset_n, .specialEventTrigger,
    .overflowPulse, .overflowFlag, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
`default_nettype wire

// file: verification/gst_src_model.sv
// Clock and gate sources standing around the timer
`timescale 1ns/10ps
`default_nettype none
module gst_src_model (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    // Levels for pin, comparator 1, comparator 2
    input  wire logic [2:0]       gateLvl,
    // Sources
    output var gst_pkg::gst_clk_in_s  clkIn,
    output var gst_pkg::gst_gate_in_s gateIn
);
    import gst_pkg::*;
    logic [4:0] tick_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_q <= 5'h00;
        end else begin
            tick_q <= tick_q + 5'h01;
        end
    end
    // Oscillators run free: pin /4, secondary /8, RC /16
    assign clkIn = '{lowPowerRcOsc: tick_q[3], secondaryOsc: tick_q[2], extClkPin: tick_q[1]};
    // period match strobes once in 32
    assign gateIn = '{comp2Out: gateLvl[2], comp1Out: gateLvl[1], periodMatch: &tick_q,
                      extGatePin: gateLvl[0]};
endmodule : gst_src_model
`default_nettype wire

// file: verification/gst_timer_tb.sv
// Self-checking bench for the gated timer
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module gst_timer_tb;
    import gst_pkg::*;
    typedef struct packed {logic [31:0] lo; logic [31:0] hi; logic [1:0] rs;} gst_exp_s;
    logic sys_clk, reset_n, specialEventTrigger, overflowPulse, overflowFlag;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] gateLvl;
    logic [15:0] seed;
    gst_clk_in_s clkIn;
    gst_gate_in_s gateIn;
    gst_exp_s expQ[$];
    gst_exp_s cur;
    int fails, checksDone, cyc, i, j, pulses;
    logic inRange;
    logic [7:0] ctlTab [12] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h41, 8'h45, 8'h75,
                                8'h81, 8'h85, 8'h89, 8'h8d, 8'hc1};
    int divTab [12] = '{1, 2, 4, 8, 2, 2, 16, 4, 4, 8, 8, 16};

    gst_timer i_dut (.sys_clk, .reset_n, .clkIn, .gateIn, .specialEventTrigger,
        .overflowPulse, .overflowFlag, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    gst_src_model i_src (.sys_clk, .reset_n, .gateLvl, .clkIn, .gateIn);

    always #2.5 sys_clk = ~sys_clk;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : finish_test

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
    endtask : wr

    // Expectation goes on the queue before the request leaves
    task automatic rd(input logic [3:0] a, input logic [31:0] lo, hi, input logic [1:0] rs);
        expQ.push_back('{lo, hi, rs});
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic rq(input logic [3:0] a, input logic [31:0] v);
        rd(a, v, v, RESP_OKAY);
    endtask : rq

    // Tolerance covers synchroniser and bus latency at both ends of the run
    task automatic meas(input logic [7:0] c, input int d);
        wr(OFF_CONTROL, 32'h0);
        wr(OFF_COUNT_VALUE, 32'h0);
        wr(OFF_CONTROL, {24'h0, c});
        repeat (128) @(posedge sys_clk);
        wr(OFF_CONTROL, 32'h0);
        if (d == 0) rq(OFF_COUNT_VALUE, 32'h0);
        else rd(OFF_COUNT_VALUE, 128 / d - 2, 136 / d + 2, RESP_OKAY);
    endtask : meas

    task automatic pinPulse;
        gateLvl <= 3'h1;
        repeat (4) @(posedge sys_clk);
        gateLvl <= 3'h0;
        repeat (4) @(posedge sys_clk);
    endtask : pinPulse

    always @(posedge sys_clk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
            cur = expQ.pop_front();
            inRange = (s_axi_rdata >= cur.lo && s_axi_rdata <= cur.hi) === 1'b1;
            `CHK("rresp", cur.rs, s_axi_rresp)
            `CHK("rdata", inRange ? s_axi_rdata : cur.lo, s_axi_rdata)
        end
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (overflowPulse === 1'b1) pulses++;
        if (cyc == 30000) begin
            fails++;
            finish_test();
        end
    end

    initial begin
        {sys_clk, reset_n, specialEventTrigger, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, gateLvl, fails, checksDone, cyc, pulses} = '0;
        s_axi_wstrb = 4'hf;
        seed = 16'h0032;
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        rq(OFF_CONTROL, 32'h0);
        rq(OFF_GATE_CONTROL, 32'h4);
        rq(OFF_COUNT_VALUE, 32'h0);
        rq(OFF_STATUS, 32'h0);
        rd(4'h2, 32'h0, 32'h0, RESP_SLVERR);
        wr(4'h1, 32'hff);
        rq(OFF_CONTROL, 32'h0);
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wr(OFF_CONTROL, {seed, seed & 16'hfffe});
            rq(OFF_CONTROL, seed[7:0] & 8'hfc);
            wr(OFF_COUNT_VALUE, {seed, seed});
            repeat (20) @(posedge sys_clk);
            rq(OFF_COUNT_VALUE, seed);
        end
        $display("test registers done");
        for (i = 0; i < 12; i++) meas(ctlTab[i], divTab[i]);
        $display("test sources done");
        wr(OFF_GATE_CONTROL, 32'hc0);
        meas(8'h01, 0);
        wr(OFF_GATE_CONTROL, 32'h80);
        meas(8'h01, 1);
        wr(OFF_GATE_CONTROL, 32'h40);
        meas(8'h01, 1);
        wr(OFF_GATE_CONTROL, 32'hc1);
        meas(8'h01, 32);
        for (i = 0; i < 3; i++) begin
            for (j = 0; j < 2; j++) begin
                gateLvl <= (j == 1) ? 3'(1 << i) : ~3'(1 << i);
                wr(OFF_GATE_CONTROL, 32'h40 | (i == 0 ? 0 : i + 1));
                rq(OFF_GATE_CONTROL, 32'h40 | (i == 0 ? 0 : i + 1) | (j << 2));
            end
        end
        gateLvl <= 3'h0;
        $display("test gate select done");
        wr(OFF_GATE_CONTROL, 32'h60);
        rq(OFF_GATE_CONTROL, 32'h60);
        pinPulse();
        rq(OFF_GATE_CONTROL, 32'h64);
        pinPulse();
        rq(OFF_GATE_CONTROL, 32'h60);
        pinPulse();
        wr(OFF_GATE_CONTROL, 32'h40);
        wr(OFF_GATE_CONTROL, 32'h60);
        rq(OFF_GATE_CONTROL, 32'h60);
        $display("test toggle done");
        wr(OFF_GATE_CONTROL, 32'hd0);
        wr(OFF_GATE_CONTROL, 32'hd8);
        rq(OFF_GATE_CONTROL, 32'hd8);
        wr(OFF_COUNT_VALUE, 32'h0);
        wr(OFF_CONTROL, 32'h01);
        for (i = 0; i < 2; i++) begin
            gateLvl <= 3'h1;
            repeat (20) @(posedge sys_clk);
            gateLvl <= 3'h0;
            repeat (10) @(posedge sys_clk);
        end
        wr(OFF_CONTROL, 32'h0);
        rd(OFF_COUNT_VALUE, 32'd18, 32'd22, RESP_OKAY);
        rq(OFF_GATE_CONTROL, 32'hd0);
        wr(OFF_GATE_CONTROL, 32'hd8);
        wr(OFF_GATE_CONTROL, 32'hc0);
        rq(OFF_GATE_CONTROL, 32'hc0);
        $display("test single pulse done");
        wr(OFF_GATE_CONTROL, 32'h0);
        wr(OFF_COUNT_VALUE, 32'hfff8);
        specialEventTrigger <= 1'b1;
        wr(OFF_CONTROL, 32'h41);
        repeat (40) @(posedge sys_clk);
        rq(OFF_COUNT_VALUE, 32'h0);
        rq(OFF_STATUS, 32'h0);
        specialEventTrigger <= 1'b0;
        wr(OFF_CONTROL, 32'h0);
        wr(OFF_COUNT_VALUE, 32'hfff0);
        wr(OFF_CONTROL, 32'h01);
        repeat (40) @(posedge sys_clk);
        wr(OFF_CONTROL, 32'h0);
        rq(OFF_STATUS, 32'h1);
        `CHK("overflowFlag", 1'b1, overflowFlag)
        `CHK("overflowPulse", 1, pulses)
        wr(OFF_STATUS, 32'h1);
        rq(OFF_STATUS, 32'h0);
        `CHK("overflowFlag", 1'b0, overflowFlag)
        $display("test trigger and overflow done");
        repeat (4) @(posedge sys_clk);
        finish_test();
    end
endmodule : gst_timer_tb
`default_nettype wire
